// ---- pkg/scs_pkg.sv ----
// Constants, enumerations, carriers and helpers for the sample clock sync selector
// Functional notes
// - Sample clock always generated inside the unit
// - Local reference: clock master, indicator steadily lit
// - Locked external source: clock slave, indicator off
// - Bad external source: local clock, indicator flashes
// - Valid source returns: relock and unmute audio
// - Stand-alone: rate follows valid external source
// - One common rate and sync, except converter
// - Input converter accepts any incoming digital rate; the code only sets src_in_active, meter still checks nominal
// - Output converter has own rate and reference
// - Wordclock output: rate, 256x or base clock; in 256x mode the code outputs the rate clock and sets wclk_x256
// - Base clock is 44.1k or 48k family
// - Rate change may be refused while ports open
// - Converted output syncs local, digital in, wordclock
package scs_pkg;

    // System clock and timing
    localparam int unsigned CLK_HZ       = 20_000_000;  // Core clock rate
    localparam int unsigned SETTLE_US    = 1000;        // Settling time after a clock switch
    localparam int unsigned SETTLE_CYC   = SETTLE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned FLASH_MS     = 250;         // Half period of indicator flashing
    localparam int unsigned FLASH_CYC    = FLASH_MS * (CLK_HZ / 1000);
    localparam int unsigned CNT_W        = 24;          // Width of settle and flash counters

    // Frequency qualification
    localparam int unsigned PER_W        = 12;          // Width of period measurement
    localparam int unsigned TOL_SHIFT    = 6;           // Tolerance is nominal / 64
    localparam int unsigned QUAL_PERIODS = 8;           // Good periods in a row before valid
    localparam int unsigned ABSENT_CYC   = 1024;        // No edge this long means absent

    // Base clock frequencies
    localparam int unsigned BASE_44K1_HZ = 44_100;
    localparam int unsigned BASE_48K_HZ  = 48_000;

    // Sync source choices
    typedef enum logic [1:0] {
        SRC_LOCAL,
        SRC_DIGITAL_AUDIO_INPUT_SOURCE,
        SRC_WORDCLOCK,
        SRC_OPTICAL
    } scs_src_t;

    // Standard sample rates
    typedef enum logic [2:0] {
        RATE_44K1, RATE_48K, RATE_88K2, RATE_96K, RATE_176K4, RATE_192K
    } scs_rate_t;

    // Wordclock output modes
    typedef enum logic [1:0] {
        WCLK_RATE, OVERSAMPLED_CLOCK_MODE, WCLK_BASE
    } scs_wclk_mode_t;

    // Placement of the rate converter
    typedef enum logic [1:0] {
        PLACE_NONE, PLACE_INPUT, PLACE_OUTPUT
    } scs_src_place_t;

    // Sync choice for a converted digital output
    typedef enum logic [1:0] {
        DO_SYNC_LOCAL, DO_SYNC_DIGITAL_IN, DO_SYNC_WORDCLOCK
    } scs_do_sync_t;

    // Supervisor states
    typedef enum logic [1:0] {
        FSM_MASTER, FSM_FALLBACK, FSM_SETTLE, FSM_SLAVE
    } scs_fsm_t;

    // Control inputs
    typedef struct packed {
        scs_src_t       sync_sel;      // Requested sync source
        logic           rate_req;      // Pulse: request a new sample rate
        scs_rate_t      rate_req_code; // Rate asked for
        logic           ports_open;    // Host application holds audio ports
        logic           standalone;    // No host attached
        scs_wclk_mode_t wclk_mode;     // Wordclock output mode
        scs_src_place_t src_place;     // Rate converter placement
        scs_do_sync_t   do_sync_sel;   // Sync for converted output
        scs_rate_t      do_rate_code;  // Rate of converted output
    } scs_ctrl_t;

    // Status outputs
    typedef struct packed {
        logic      sample_tick;    // Pulse per sample period
        logic      sample_level;   // Sample clock square wave
        logic      clock_slave;    // Locked to external source
        logic      master_led;     // Master indicator drive
        logic      fallback;       // Local clock overriding a bad source
        logic      audio_mute;     // Audio held silent
        scs_rate_t rate_cur;       // Rate now in effect
        logic      rate_refused;   // Pulse: rate change refused
        logic      wclk_out;       // Wordclock output level
        logic      wclk_x256;      // Wordclock multiplier wanted downstream
        logic      do_tick;        // Pulse per digital output sample
        logic      src_in_active;  // Converter sits on digital input
        logic      src_out_active; // Converter sits on digital output
    } scs_stat_t;

    // Frequency of a rate code
    function automatic int unsigned scs_rate_hz(scs_rate_t r);
        unique case (r)
            RATE_44K1:  return BASE_44K1_HZ;
            RATE_48K:   return BASE_48K_HZ;
            RATE_88K2:  return 2 * BASE_44K1_HZ;
            RATE_96K:   return 2 * BASE_48K_HZ;
            RATE_176K4: return 4 * BASE_44K1_HZ;
            RATE_192K:  return 4 * BASE_48K_HZ;
            default:    return BASE_48K_HZ;
        endcase
    endfunction

    // Nominal sample period in core clock cycles
    function automatic logic [PER_W-1:0] scs_nom_period(scs_rate_t r);
        return PER_W'(CLK_HZ / scs_rate_hz(r));
    endfunction

    // Phase increment of a 32-bit accumulator for a rate
    function automatic logic [31:0] scs_nco_inc(scs_rate_t r);
        logic [63:0] p;
        p = (64'(scs_rate_hz(r)) << 32) / 64'(CLK_HZ);
        return p[31:0];
    endfunction

    // Octave above the base rate: 0, 1 or 2
    function automatic logic [1:0] scs_octave(scs_rate_t r);
        return (r == RATE_44K1 || r == RATE_48K) ? 2'h0 :
               (r == RATE_88K2 || r == RATE_96K) ? 2'h1 : 2'h2;
    endfunction

endpackage

// ---- core/scs_period_meter.sv ----
// Period meter and qualifier for one external sync input
`timescale 1ns/1ns
module scs_period_meter #(
    parameter int unsigned PER_W     = scs_pkg::PER_W,
    parameter int unsigned QUAL      = scs_pkg::QUAL_PERIODS,
    parameter int unsigned TOL_SHIFT = scs_pkg::TOL_SHIFT,
    parameter int unsigned ABSENT    = scs_pkg::ABSENT_CYC
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             clk_level,  // External clock, synchronous samples
    input  wire logic [PER_W-1:0] nominal,    // Expected period in cycles
    output logic      [PER_W-1:0] period,     // Last measured period
    output logic                  valid       // Source qualified
);
    localparam int unsigned QW = $clog2(QUAL + 1);

    // All meter state
    typedef struct packed {
        logic             prev;     // Previous input level
        logic [PER_W-1:0] cnt;      // Cycles since last rising edge
        logic [PER_W-1:0] period;
        logic [QW-1:0]    good;     // Good periods in a row
        logic             valid;
    } scs_meter_t;

    scs_meter_t s_reg;
    scs_meter_t s_next;
    logic [PER_W-1:0] meas;  // Period ending at this edge
    logic [PER_W-1:0] diff;  // Distance from nominal

    // Measure each period and qualify against the tolerance window
    always_comb begin
        s_next      = s_reg;
        s_next.prev = clk_level;
        meas        = s_reg.cnt + PER_W'(1);
        diff        = (meas > nominal) ? meas - nominal : nominal - meas;
        if (s_reg.cnt != '1) begin
            s_next.cnt = meas;  // Saturates on a dead input
        end
        if (clk_level && !s_reg.prev) begin
            s_next.cnt    = '0;
            s_next.period = meas;
            if (diff <= (nominal >> TOL_SHIFT)) begin
                if (s_reg.good != QW'(QUAL)) begin
                    s_next.good = s_reg.good + QW'(1);
                end
                s_next.valid = (s_reg.good >= QW'(QUAL - 1));
            end else begin
                // Off-rate: start the interval again
                s_next.good  = '0;
                s_next.valid = 1'b0;
            end
        end else if (s_reg.cnt >= PER_W'(ABSENT)) begin
            // Absent source
            s_next.good  = '0;
            s_next.valid = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign period = s_reg.period;
    assign valid  = s_reg.valid;
endmodule

// ---- core/scs_sync_select.sv ----
// Sample clock source selection, supervision and wordclock output
`timescale 1ns/1ns
module scs_sync_select #(
    parameter int unsigned SETTLE_CYC = scs_pkg::SETTLE_CYC,  // Mute hold after a switch
    parameter int unsigned FLASH_CYC  = scs_pkg::FLASH_CYC    // Indicator flash half period
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire scs_pkg::scs_ctrl_t ctrl,     // Configuration and requests
    input  wire logic [2:0]        ext_clk,  // Digital in, wordclock, optical clock levels
    output scs_pkg::scs_stat_t     stat      // Status, all registered
);
    // All block state
    typedef struct packed {
        scs_pkg::scs_fsm_t  fsm;
        scs_pkg::scs_src_t  src_cur;      // Source locked or being switched to
        logic               tgt_slave;    // Settle ends in slave mode
        scs_pkg::scs_rate_t rate_sel;     // Accepted nominated rate
        logic [31:0]        acc;          // Local sample clock accumulator
        logic [31:0]        do_acc;       // Converted output accumulator
        logic [2:0]         ext_prev;     // Previous external levels
        logic [scs_pkg::CNT_W-1:0] settle_cnt;
        logic [scs_pkg::CNT_W-1:0] flash_cnt;
        logic               flash;        // Flashing phase
        logic [1:0]         base_div;     // Divider for the base clock
        scs_pkg::scs_stat_t stat;
    } scs_state_t;

    scs_state_t s_reg;
    scs_state_t s_next;

    logic [scs_pkg::PER_W-1:0] per [3];     // Measured periods
    logic [scs_pkg::PER_W-1:0] nom [3];     // Nominal periods fed to the meters
    logic [2:0]                ext_ok;      // Qualified sources
    scs_pkg::scs_rate_t        cls [3];     // Rate each source appears to run at

    // One meter per external source
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_meter
            scs_period_meter u_meter (
                .clock     (clock),
                .rst       (rst),
                .clk_level (ext_clk[gi]),
                .nominal   (nom[gi]),
                .period    (per[gi]),
                .valid     (ext_ok[gi])
            );
        end
    endgenerate

    // Classify each measured period; stand-alone checks against the rate found
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            cls[i] = s_reg.rate_sel;
            for (int r = 0; r < 6; r++) begin
                if (per[i] >= scs_pkg::scs_nom_period(scs_pkg::scs_rate_t'(r)) - PER_W_TOL(r) &&
                    per[i] <= scs_pkg::scs_nom_period(scs_pkg::scs_rate_t'(r)) + PER_W_TOL(r)) begin
                    cls[i] = scs_pkg::scs_rate_t'(r);
                end
            end
            nom[i] = ctrl.standalone ? scs_pkg::scs_nom_period(cls[i])
                                     : scs_pkg::scs_nom_period(s_reg.rate_sel);
        end
    end

    // Tolerance window for a rate index
    function automatic logic [scs_pkg::PER_W-1:0] PER_W_TOL(int r);
        return scs_pkg::scs_nom_period(scs_pkg::scs_rate_t'(r)) >> scs_pkg::TOL_SHIFT;
    endfunction

    logic       ext_sel;    // An external source is selected
    logic [1:0] sel_idx;    // Meter index of the selected source
    logic [1:0] cur_idx;    // Meter index of the current source
    logic       sel_valid;  // Selected source qualified
    logic       rate_ok;    // Rate request accepted
    logic       lvl;        // Next sample clock level
    logic       base_lvl;   // Next base clock level
    logic       do_lvl;     // Converted output clock level
    scs_pkg::scs_rate_t rate_eff;

    // Supervisor, clock generation and outputs
    always_comb begin
        s_next     = s_reg;
        ext_sel    = (ctrl.sync_sel != scs_pkg::SRC_LOCAL);
        sel_idx    = 2'(ctrl.sync_sel) - 2'h1;
        cur_idx    = 2'(s_reg.src_cur) - 2'h1;
        sel_valid  = ext_sel && ext_ok[sel_idx];
        rate_ok    = ctrl.rate_req && !ctrl.ports_open;
        s_next.ext_prev = ext_clk;

        // Rate requests are refused while ports are held open
        s_next.stat.rate_refused = ctrl.rate_req && ctrl.ports_open;
        if (rate_ok) begin
            s_next.rate_sel = ctrl.rate_req_code;
        end

        // Flash timer free-runs; only its use depends on state
        if (s_reg.flash_cnt == '0) begin
            s_next.flash_cnt = scs_pkg::CNT_W'(FLASH_CYC - 1);
            s_next.flash     = !s_reg.flash;
        end else begin
            s_next.flash_cnt = s_reg.flash_cnt - scs_pkg::CNT_W'(1);
        end

        // Clock source supervision
        unique case (s_reg.fsm)
            scs_pkg::FSM_MASTER, scs_pkg::FSM_FALLBACK: begin
                if (sel_valid || rate_ok) begin
                    // Switch to a source, or retune local: mute meanwhile
                    s_next.fsm        = scs_pkg::FSM_SETTLE;
                    s_next.tgt_slave  = sel_valid;
                    s_next.src_cur    = ctrl.sync_sel;
                    s_next.settle_cnt = scs_pkg::CNT_W'(SETTLE_CYC - 1);
                end else begin
                    s_next.fsm = ext_sel ? scs_pkg::FSM_FALLBACK : scs_pkg::FSM_MASTER;
                end
            end
            scs_pkg::FSM_SETTLE: begin
                if (s_reg.settle_cnt != '0) begin
                    s_next.settle_cnt = s_reg.settle_cnt - scs_pkg::CNT_W'(1);
                end else if (s_reg.tgt_slave && sel_valid && ctrl.sync_sel == s_reg.src_cur) begin
                    s_next.fsm = scs_pkg::FSM_SLAVE;
                end else begin
                    s_next.fsm = ext_sel ? scs_pkg::FSM_FALLBACK : scs_pkg::FSM_MASTER;
                end
            end
            scs_pkg::FSM_SLAVE: begin
                if (!sel_valid || ctrl.sync_sel != s_reg.src_cur || (rate_ok && !ctrl.standalone)) begin
                    // Lost, re-selected or retuned: mute across the change
                    s_next.fsm        = scs_pkg::FSM_SETTLE;
                    s_next.tgt_slave  = sel_valid;
                    s_next.src_cur    = ctrl.sync_sel;
                    s_next.settle_cnt = scs_pkg::CNT_W'(SETTLE_CYC - 1);
                end
            end
        endcase

        // Rate in force; stand-alone slave follows the source
        rate_eff = (s_next.fsm == scs_pkg::FSM_SLAVE && ctrl.standalone) ? cls[cur_idx] : s_next.rate_sel;
        s_next.stat.rate_cur = rate_eff;

        // Local reference always runs so fallback is instant
        s_next.acc = s_reg.acc + scs_pkg::scs_nco_inc(s_next.rate_sel);
        // Slave clock is taken from the source through this block, never from the host
        lvl = (s_next.fsm == scs_pkg::FSM_SLAVE) ? ext_clk[cur_idx] : s_next.acc[31];
        s_next.stat.sample_level = lvl;
        s_next.stat.sample_tick  = lvl && !s_reg.stat.sample_level;

        // Mode and indicator
        s_next.stat.clock_slave = (s_next.fsm == scs_pkg::FSM_SLAVE);
        s_next.stat.fallback    = (s_next.fsm == scs_pkg::FSM_FALLBACK);
        s_next.stat.audio_mute  = (s_next.fsm == scs_pkg::FSM_SETTLE) ||
                                  (s_next.fsm == scs_pkg::FSM_FALLBACK);
        unique case (s_next.fsm)
            scs_pkg::FSM_MASTER:   s_next.stat.master_led = 1'b1;
            scs_pkg::FSM_FALLBACK: s_next.stat.master_led = s_next.flash;
            scs_pkg::FSM_SETTLE:   s_next.stat.master_led = !s_next.tgt_slave;
            scs_pkg::FSM_SLAVE:    s_next.stat.master_led = 1'b0;
        endcase

        // Base clock: divide the sample clock by 1, 2 or 4 for octave 0, 1 or 2 of the rate
        if (s_next.stat.sample_tick) begin
            s_next.base_div = s_reg.base_div + 2'h1;
        end
        unique case (scs_pkg::scs_octave(rate_eff))
            2'h0:    base_lvl = lvl;
            2'h1:    base_lvl = s_next.base_div[0];
            default: base_lvl = s_next.base_div[1];
        endcase

        // Wordclock output; the 256x multiple is made by an external multiplier
        unique case (ctrl.wclk_mode)
            scs_pkg::WCLK_RATE:              s_next.stat.wclk_out = lvl;
            scs_pkg::OVERSAMPLED_CLOCK_MODE: s_next.stat.wclk_out = lvl;
            scs_pkg::WCLK_BASE:              s_next.stat.wclk_out = base_lvl;
            default:                         s_next.stat.wclk_out = lvl;
        endcase
        s_next.stat.wclk_x256 = (ctrl.wclk_mode == scs_pkg::OVERSAMPLED_CLOCK_MODE);

        // Converter placement; only flagged here, the digital input meter is unchanged
        s_next.stat.src_in_active  = (ctrl.src_place == scs_pkg::PLACE_INPUT);
        s_next.stat.src_out_active = (ctrl.src_place == scs_pkg::PLACE_OUTPUT);

        // Converted output timing, with its own rate and reference
        s_next.do_acc = s_reg.do_acc + scs_pkg::scs_nco_inc(ctrl.do_rate_code);
        unique case (ctrl.do_sync_sel)
            scs_pkg::DO_SYNC_LOCAL:      do_lvl = s_next.do_acc[31];
            scs_pkg::DO_SYNC_DIGITAL_IN: do_lvl = ext_clk[0];
            scs_pkg::DO_SYNC_WORDCLOCK:  do_lvl = ext_clk[1];
            default:                     do_lvl = s_next.do_acc[31];
        endcase
        if (s_next.stat.src_out_active) begin
            s_next.stat.do_tick = (ctrl.do_sync_sel == scs_pkg::DO_SYNC_LOCAL)
                                ? (s_next.do_acc[31] && !s_reg.do_acc[31])
                                : (do_lvl && !s_reg.ext_prev[ctrl.do_sync_sel == scs_pkg::DO_SYNC_WORDCLOCK]);
        end else begin
            // Without an output converter the output shares the unit clock
            s_next.stat.do_tick = s_next.stat.sample_tick;
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (rst) begin
            s_reg          <= '0;
            s_reg.fsm      <= scs_pkg::FSM_MASTER;
            s_reg.src_cur  <= scs_pkg::SRC_LOCAL;
            s_reg.rate_sel <= scs_pkg::RATE_48K;
            s_reg.stat.master_led <= 1'b1;
            s_reg.stat.rate_cur   <= scs_pkg::RATE_48K;
        end else begin
            s_reg <= s_next;
        end
    end

    assign stat = s_reg.stat;
endmodule

// ---- dv/scs_ext_src.sv ----
// Far-side sync sources: one square wave on each enabled sync input
`timescale 1ns/1ns
module scs_ext_src (
    input  wire logic        clock,
    input  wire logic [2:0]  en,     // Source plugged in, per input
    input  wire logic [11:0] half,   // Half period in core cycles
    output logic      [2:0]  ext_clk // Levels; an unplugged input rests low
);
    logic [11:0] cnt_reg; // Half period counter
    logic        lvl_reg; // Shared wave level
    initial begin
        cnt_reg = 12'h000;
        lvl_reg = 1'b0;
    end
    // House sync runs free, so the unit and this equipment share one clock
    // Plain always: the initial block above also writes these registers
    always @(posedge clock) begin
        cnt_reg <= (cnt_reg + 12'h001 >= half) ? 12'h000 : cnt_reg + 12'h001;
        lvl_reg <= (cnt_reg + 12'h001 >= half) ? ~lvl_reg : lvl_reg;
    end
    assign ext_clk = en & {3{lvl_reg}};
endmodule

// ---- dv/scs_sync_select_sva.sv ----
// Checker for the sample clock sync selector, bound to its top module
`timescale 1ns/1ns
module scs_sync_select_sva #(
    parameter int unsigned SETTLE_CYC = 20,
    parameter int unsigned FLASH_CYC  = 8
) (
    input wire logic               clock,
    input wire logic               rst,
    input wire scs_pkg::scs_ctrl_t ctrl,
    input wire logic [2:0]         ext_clk,
    input wire scs_pkg::scs_stat_t stat
);
    logic [31:0] led_run;  // Cycles the flashing indicator held one level
    logic [31:0] mute_run; // Cycles of one settle mute
    logic        led_q;    // Indicator one cycle ago
    // Run counters: a flash or settle that sticks shows up as an overrun
    always_ff @(posedge clock) begin
        led_q <= stat.master_led;
        led_run <= (rst || !stat.fallback || stat.master_led != led_q) ? 32'h0 : led_run + 32'h1;
        mute_run <= (rst || !stat.audio_mute || stat.fallback) ? 32'h0 : mute_run + 32'h1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence acc_s;
        ctrl.rate_req && !ctrl.ports_open && !ctrl.standalone;
    endsequence
    sequence tick_s;
        stat.clock_slave && ctrl.sync_sel == scs_pkg::SRC_WORDCLOCK && $rose(ext_clk[1]);
    endsequence
    slave_dark_a: assert property (stat.clock_slave |-> !stat.master_led && !stat.audio_mute)
        else $error("indicator or mute on while slave");
    master_lit_a: assert property (!stat.clock_slave && !stat.audio_mute |-> stat.master_led)
        else $error("indicator dark in local mode");
    flash_len_a: assert property (led_run <= FLASH_CYC + 1)
        else $error("indicator stopped flashing");
    fallback_local_a: assert property (stat.fallback |-> !stat.clock_slave && stat.audio_mute)
        else $error("fallback not local and muted");
    refuse_pulse_a: assert property (ctrl.rate_req && ctrl.ports_open |-> ##[1:2] stat.rate_refused)
        else $error("refused request gave no pulse");
    accept_mute_a: assert property (acc_s |-> ##[1:2] stat.audio_mute)
        else $error("rate change without mute");
    settle_len_a: assert property (mute_run <= SETTLE_CYC + 2)
        else $error("settle mute overran");
    slave_tick_a: assert property (tick_s |-> ##[1:3] stat.sample_tick)
        else $error("sample tick not following source");
    x256_flag_a: assert property (!$past(rst) |->
        stat.wclk_x256 == ($past(ctrl.wclk_mode) == scs_pkg::OVERSAMPLED_CLOCK_MODE))
        else $error("oversampled flag wrong");
    conv_flags_a: assert property (!$past(rst) |-> stat.src_in_active == ($past(ctrl.src_place) ==
        scs_pkg::PLACE_INPUT) && stat.src_out_active == ($past(ctrl.src_place) == scs_pkg::PLACE_OUTPUT))
        else $error("converter placement flags wrong");
endmodule
bind scs_sync_select scs_sync_select_sva #(.SETTLE_CYC(SETTLE_CYC), .FLASH_CYC(FLASH_CYC)) u_sva (
    .clock(clock), .rst(rst), .ctrl(ctrl), .ext_clk(ext_clk), .stat(stat));

// ---- dv/testbench.sv ----
// Self-checking bench for the sample clock sync selector
`timescale 1ns/1ns
module testbench;
    localparam int SC = 20; // Short settle so the run stays brief
    localparam int FC = 8;  // Short flash half period
    logic               clock;
    logic               rst;
    scs_pkg::scs_ctrl_t ctrl;
    scs_pkg::scs_stat_t stat;
    scs_pkg::scs_rate_t rr;
    logic [2:0]         ext_clk;
    logic [2:0]         en;
    logic [11:0]        half;
    logic               seen;
    int                 tg;
    int                 tw;
    int                 ts;
    logic [1:0]         pv;
    int                 fail_count;
    int                 checks_done;
    scs_sync_select #(.SETTLE_CYC(SC), .FLASH_CYC(FC)) dut (.clock(clock), .rst(rst), .ctrl(ctrl),
        .ext_clk(ext_clk), .stat(stat));
    scs_ext_src far (.clock(clock), .en(en), .half(half), .ext_clk(ext_clk));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic chk(input logic [2:0] got, input logic [2:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // One-cycle rate request; seen catches the refusal pulse
    task automatic req(input scs_pkg::scs_rate_t r);
        ctrl.rate_req_code = r;
        ctrl.rate_req = 1'b1;
        @(negedge clock);
        ctrl.rate_req = 1'b0;
        seen = stat.rate_refused;
        @(negedge clock);
        seen = seen | stat.rate_refused;
    endtask
    // Bounded wait: k 0 for slave lock, 1 for fallback
    task automatic wt(input int k, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(negedge clock);
            if ((k == 0 && stat.clock_slave === 1'b1) || (k == 1 && stat.fallback === 1'b1))
                return;
        end
        chk(3'h0, 3'h1, "wait timed out");
    endtask
    initial begin
        rst = 1'b1;
        ctrl = '0;
        en = 3'h0;
        half = 12'h0d0;
        fail_count = 0;
        checks_done = 0;
        repeat (5) @(negedge clock);
        rst = 1'b0;
        chk(stat.master_led, 3'h1, "led after reset");
        chk(stat.rate_cur, scs_pkg::RATE_48K, "rate after reset");
        $display("Test reset done");
        ctrl.ports_open = 1'b1;
        req(scs_pkg::RATE_96K);
        chk(seen, 3'h1, "refusal pulse");
        chk(stat.rate_cur, scs_pkg::RATE_48K, "rate kept");
        ctrl.ports_open = 1'b0;
        for (int r = 0; r < 7; r++) begin
            rr = (r == 6) ? scs_pkg::RATE_48K : scs_pkg::scs_rate_t'(r);
            req(rr);
            chk(seen, 3'h0, "accepted");
            chk(stat.rate_cur, rr, "new rate");
            chk(stat.audio_mute, 3'h1, "mute in switch");
            repeat (SC + 5) @(negedge clock);
            chk(stat.audio_mute, 3'h0, "unmute after settle");
            chk(stat.master_led, 3'h1, "local led");
        end
        $display("Test rate requests done");
        en = 3'h7;
        ctrl.sync_sel = scs_pkg::SRC_WORDCLOCK;
        wt(0, 8000);
        chk(stat.master_led, 3'h0, "slave led");
        chk(stat.audio_mute, 3'h0, "slave audio");
        for (int m = 0; m < 3; m++) begin
            ctrl.wclk_mode = scs_pkg::scs_wclk_mode_t'(m);
            ctrl.src_place = scs_pkg::scs_src_place_t'(m);
            ctrl.do_sync_sel = scs_pkg::scs_do_sync_t'(m);
            repeat (3) @(negedge clock);
            chk({2'h0, stat.wclk_x256}, {2'h0, m == 1}, "x256 flag");
            chk({2'h0, stat.src_in_active}, {2'h0, m == 1}, "input converter");
            chk({2'h0, stat.src_out_active}, {2'h0, m == 2}, "output converter");
        end
        // Two source periods of 416 cycles: exactly two edges of each clock
        tg = 0;
        tw = 0;
        ts = 0;
        for (int i = 0; i < 832; i++) begin
            pv = {stat.wclk_out, stat.sample_level};
            @(negedge clock);
            tg += stat.do_tick;
            tw += (stat.wclk_out && !pv[1]) ? 1 : 0;
            ts += (stat.sample_level && !pv[0]) ? 1 : 0;
        end
        chk(3'(tg), 3'h2, "converted output ticks");
        chk(3'(tw), 3'h2, "base clock edges");
        chk(3'(ts), 3'h2, "slave sample edges");
        $display("Test lock and wordclock done");
        half = 12'h096;
        wt(1, 3000);
        chk(stat.clock_slave, 3'h0, "fallback local");
        tg = 0;
        for (int i = 0; i < 2 * FC + 2; i++) begin
            seen = stat.master_led;
            @(negedge clock);
            tg += (stat.master_led !== seen) ? 1 : 0;
        end
        chk(3'(tg), (tg >= 2 && tg <= 3) ? 3'(tg) : 3'h2, "flash toggles");
        half = 12'h0d0;
        wt(0, 8000);
        chk(stat.audio_mute, 3'h0, "relock audio");
        $display("Test fallback and relock done");
        ctrl.standalone = 1'b1;
        ctrl.sync_sel = scs_pkg::SRC_DIGITAL_AUDIO_INPUT_SOURCE;
        half = 12'h0e2;
        repeat (1100) @(negedge clock);
        wt(0, 8000);
        chk(stat.rate_cur, scs_pkg::RATE_44K1, "rate follows source");
        $display("Test stand-alone done");
        end_of_test();
    end
    initial begin
        #(40000 * 50);
        fail_count++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        end_of_test();
    end
endmodule
